/* design/msd_pkg.sv */
// Shared constants and types for the message start sequence detector
package msd_pkg;
	localparam int NUM_SEQ = 5;
	localparam int NUM_POS = 5;
	localparam int CHAR_W  = 8;

	localparam logic [7:0] ADR_CTRL     = 8'h00;
	localparam logic [7:0] ADR_STATUS   = 8'h04;
	localparam logic [7:0] ADR_END      = 8'h08;
	localparam logic [7:0] ADR_SEQ_BASE = 8'h10;
	localparam logic [7:0] SEQ_STRIDE   = 8'h08;
	localparam logic [7:0] SEQ_HI_OFS   = 8'h04;

	localparam int CTRL_RUN_BIT  = 8;
	localparam int ST_EVAL_BIT   = 0;
	localparam int ST_SEEN_BIT   = 1;
	localparam int ST_ID_LSB     = 4;
	localparam int ST_CNT_LSB    = 8;
	localparam int END_CMD_BIT   = 0;
	localparam int HI_CHECK_LSB  = 8;

	localparam logic [2:0] CNT_FULL = 3'h5;

	typedef logic [CHAR_W-1:0] char_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic  valid;
		char_t data;
	} rx_char_t;

	typedef struct packed {
		char_t [NUM_POS-1:0] value;
		logic  [NUM_POS-1:0] check;
	} seq_cfg_t;

	typedef enum logic [0:0] {
		ST_HUNT = 1'b0,
		ST_EVAL = 1'b1
	} mode_t;

	typedef struct packed {
		mode_t                    mode;
		logic                     run;
		logic [NUM_SEQ-1:0]       seq_en;
		seq_cfg_t [NUM_SEQ-1:0]   cfg;
		char_t [NUM_POS-2:0]      hist;
		logic [2:0]               cnt;
		logic                     seen;
		logic [2:0]               match_id;
		logic                     start;
		logic                     ack;
		logic [31:0]              rdat;
	} state_t;
endpackage

/* design/start_seq_compare.sv */
// One start sequence compared against the newest received characters
`timescale 1ns/1ps
`default_nettype none
module start_seq_compare
(
	input  wire logic [msd_pkg::NUM_POS-1:0][msd_pkg::CHAR_W-1:0] i_win,
	input  wire logic [2:0]                                       i_cnt,
	input  wire msd_pkg::seq_cfg_t                                i_cfg,
	input  wire logic                                             i_en,
	output logic                                                  o_hit
);
	// Span ends at the last checked position; trailing ignores are not part
	function automatic logic [2:0] seq_len(input logic [4:0] chk);
		logic [2:0] len;
		len = 3'h0;
		for (int i = 0; i < msd_pkg::NUM_POS; i++)
			if (chk[i])
				len = 3'(i + 1);
		return len;
	endfunction

	logic [2:0] len;

	always_comb
	begin
		len = seq_len(i_cfg.check);
		// Leading wildcards still need a real character present
		o_hit = i_en && (len != 3'h0) && (i_cnt >= len);
		for (int p = 0; p < msd_pkg::NUM_POS; p++)
			if ((p < int'(len)) && i_cfg.check[p]
				&& (i_win[int'(len) - 1 - p] != i_cfg.value[p]))
				o_hit = 1'b0;
	end
endmodule // start_seq_compare
`default_nettype wire

/* design/msg_start_detector.sv */
// Message start sequence detector with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
module msg_start_detector
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_sys_rst,
	input  wire msd_pkg::wb_req_t  i_wb,
	output msd_pkg::wb_rsp_t       o_wb,
	input  wire msd_pkg::rx_char_t i_rx,
	input  wire logic              i_msg_end,
	output logic                   o_start,
	output logic [2:0]             o_match_id,
	output logic                   o_end_eval
);
	localparam int NS = msd_pkg::NUM_SEQ;
	localparam int NP = msd_pkg::NUM_POS;

	msd_pkg::state_t s_r;
	msd_pkg::state_t s_nxt;

	logic [NP-1:0][msd_pkg::CHAR_W-1:0] win;
	logic [2:0]                          cnt_new;
	logic [NS-1:0]                       hit;
	logic                                acc;
	logic                                wr;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		return r;
	endfunction

	function automatic logic seq_adr(input logic [7:0] adr, input int n,
		input logic hi);
		logic [7:0] base;
		base = 8'(msd_pkg::ADR_SEQ_BASE + 8'(n) * msd_pkg::SEQ_STRIDE);
		return adr == (hi ? 8'(base + msd_pkg::SEQ_HI_OFS) : base);
	endfunction

	// Newest character at index 0, older ones behind it
	assign win     = {s_r.hist, i_rx.data};
	assign cnt_new = (s_r.cnt < msd_pkg::CNT_FULL) ? 3'(s_r.cnt + 3'h1)
		: s_r.cnt;
	assign acc     = i_wb.cyc && i_wb.stb && !s_r.ack;
	// Writes land on the edge at which the master sees ack
	assign wr      = i_wb.cyc && i_wb.stb && i_wb.we && s_r.ack;

	generate
		for (genvar g = 0; g < NS; g++)
		begin : g_seq
			start_seq_compare u_cmp
			(
				.i_win (win),
				.i_cnt (cnt_new),
				.i_cfg (s_r.cfg[g]),
				.i_en  (s_r.seq_en[g]),
				.o_hit (hit[g])
			);
		end
	endgenerate

	always_comb
	begin
		logic [31:0] tmp;
		tmp = 32'h0;
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		s_nxt.ack = acc;
		s_nxt.rdat = 32'h0;

		// Register writes
		if (wr)
		begin
			if (i_wb.adr == msd_pkg::ADR_CTRL)
			begin
				tmp = merge({23'h0, s_r.run, 3'h0, s_r.seq_en}, i_wb.dat,
					i_wb.sel);
				s_nxt.seq_en = tmp[NS-1:0];
				s_nxt.run = tmp[msd_pkg::CTRL_RUN_BIT];
			end
			else if (i_wb.adr == msd_pkg::ADR_STATUS)
			begin
				if (i_wb.sel[0] && i_wb.dat[msd_pkg::ST_SEEN_BIT])
					s_nxt.seen = 1'b0;
			end
			for (int n = 0; n < NS; n++)
			begin
				if (seq_adr(i_wb.adr, n, 1'b0))
					s_nxt.cfg[n].value[3:0] = merge(s_r.cfg[n].value[3:0],
						i_wb.dat, i_wb.sel);
				if (seq_adr(i_wb.adr, n, 1'b1))
				begin
					tmp = merge({19'h0, s_r.cfg[n].check, s_r.cfg[n].value[4]},
						i_wb.dat, i_wb.sel);
					s_nxt.cfg[n].value[4] = tmp[7:0];
					s_nxt.cfg[n].check = tmp[msd_pkg::HI_CHECK_LSB +: NP];
				end
			end
		end

		// Register reads, unmapped reads return zero
		if (acc && !i_wb.we)
		begin
			if (i_wb.adr == msd_pkg::ADR_CTRL)
				s_nxt.rdat = {23'h0, s_r.run, 3'h0, s_r.seq_en};
			else if (i_wb.adr == msd_pkg::ADR_STATUS)
				s_nxt.rdat = {21'h0, s_r.cnt, 1'b0, s_r.match_id, 2'h0,
					s_r.seen, s_r.mode == msd_pkg::ST_EVAL};
			for (int n = 0; n < NS; n++)
			begin
				if (seq_adr(i_wb.adr, n, 1'b0))
					s_nxt.rdat = s_r.cfg[n].value[3:0];
				if (seq_adr(i_wb.adr, n, 1'b1))
					s_nxt.rdat = {19'h0, s_r.cfg[n].check, s_r.cfg[n].value[4]};
			end
		end

		case (s_r.mode)
			msd_pkg::ST_HUNT:
			begin
				if (s_r.run && i_rx.valid)
				begin
					s_nxt.hist = win[NP-2:0];
					s_nxt.cnt = cnt_new;
					if (|hit)
					begin
						s_nxt.mode = msd_pkg::ST_EVAL;
						s_nxt.start = 1'b1;
						s_nxt.seen = 1'b1;
						// Lowest index wins when several match together
						for (int n = NS - 1; n >= 0; n--)
							if (hit[n])
								s_nxt.match_id = 3'(n);
					end
				end
			end
			msd_pkg::ST_EVAL:
			begin
				// End logic or software hands back to hunting, fresh history
				if (i_msg_end || !s_r.run || (wr && i_wb.adr == msd_pkg::ADR_END
					&& i_wb.sel[0] && i_wb.dat[msd_pkg::END_CMD_BIT]))
				begin
					s_nxt.mode = msd_pkg::ST_HUNT;
					s_nxt.cnt = 3'h0;
				end
			end
			default:
				s_nxt.mode = msd_pkg::ST_HUNT;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign o_wb.ack   = s_r.ack;
	assign o_wb.dat   = s_r.rdat;
	assign o_start    = s_r.start;
	assign o_match_id = s_r.match_id;
	assign o_end_eval = s_r.mode == msd_pkg::ST_EVAL;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	start_enters_eval_a: assert property (o_start |-> o_end_eval)
		else $error("start without end evaluation");
	start_single_a: assert property (o_start |=> !o_start)
		else $error("start pulse longer than one cycle");
	start_enabled_a: assert property (
		s_nxt.start |-> s_r.seq_en[s_nxt.match_id])
		else $error("start from a disabled sequence");
	any_hit_start_a: assert property (
		(!o_end_eval && s_r.run && i_rx.valid && (|hit)) |=> o_start)
		else $error("enabled match did not start message");
	eval_from_char_a: assert property (
		$rose(o_end_eval) |-> $past(i_rx.valid) && $past(|hit))
		else $error("evaluation began without a matching character");
	start_count_a: assert property (
		o_start |-> s_r.cnt >= 3'h1)
		else $error("start with empty history");
	eval_hold_a: assert property (
		(o_end_eval && !i_msg_end && s_r.run && !wr) |=> o_end_eval)
		else $error("evaluation dropped without an end");
	wb_ack_once_a: assert property (o_wb.ack |=> !o_wb.ack)
		else $error("ack held for two cycles");
	wb_answer_a: assert property (
		(i_wb.cyc && i_wb.stb && !o_wb.ack) |=> o_wb.ack)
		else $error("request not answered in one cycle");
endmodule // msg_start_detector
`default_nettype wire

/* verif/char_source.sv */
// Remote serial transmitter model feeding the received character stream
`timescale 1ns/1ps
`default_nettype none
module char_source
(
	input  wire logic        i_ref_clk,
	output msd_pkg::rx_char_t o_rx
);
	initial o_rx = '0;

	// Back-to-back characters; idle data inverts so stale bytes never match
	task automatic send(input msd_pkg::char_t q[$]);
		foreach (q[k])
		begin
			@(posedge i_ref_clk);
			o_rx <= '{valid: 1'b1, data: q[k]};
		end
		@(posedge i_ref_clk);
		o_rx <= '{valid: 1'b0, data: ~q[q.size()-1]};
	endtask
endmodule // char_source
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the message start sequence detector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic              i_ref_clk;
	logic              i_sys_rst;
	msd_pkg::wb_req_t  i_wb;
	msd_pkg::wb_rsp_t  o_wb;
	msd_pkg::rx_char_t rx;
	logic              i_msg_end;
	logic              o_start;
	logic [2:0]        o_match_id;
	logic              o_end_eval;
	int                n_errors;
	int                compares;
	logic [31:0]       rd;

	msg_start_detector u_msg_start_detector (.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst), .i_wb(i_wb), .o_wb(o_wb), .i_rx(rx),
		.i_msg_end(i_msg_end), .o_start(o_start),
		.o_match_id(o_match_id), .o_end_eval(o_end_eval));
	char_source u_char_source (.i_ref_clk(i_ref_clk), .o_rx(rx));

	initial
	begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	task automatic stop_test();
		$display("Errors %0d, compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge i_ref_clk);
		i_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		n = 0;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (o_wb.ack !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			n_errors++;
			stop_test();
		end
		rd = o_wb.dat;
		i_wb <= '0;
	endtask

	// Sequence 0 wildcards the middle, sequence 1 has a leading wildcard
	task automatic t_config();
		wb(1'b1, msd_pkg::ADR_SEQ_BASE, 32'h0000006A);
		wb(1'b1, msd_pkg::ADR_SEQ_BASE + 8'h04, 32'h0000111C);
		wb(1'b1, msd_pkg::ADR_SEQ_BASE + 8'h08, 32'h006A6A00);
		wb(1'b1, msd_pkg::ADR_SEQ_BASE + 8'h0C, 32'h00000600);
		wb(1'b1, msd_pkg::ADR_CTRL, 32'h00000101);
		wb(1'b0, msd_pkg::ADR_CTRL, 32'h0);
		chk("ctrl", rd, 32'h00000101);
		wb(1'b0, 8'h60, 32'h0);
		chk("unmapped", rd, 32'h0);
	endtask

	task automatic t_five();
		u_char_source.send('{8'h55, 8'h6A, 8'h6A});
		#1;
		chk("disabled seq", o_start, 1'b0);
		u_char_source.send('{8'h6A, 8'h12, 8'h14, 8'h18, 8'h1D});
		#1;
		chk("last byte", o_start, 1'b0);
		u_char_source.send('{8'h6A, 8'h44, 8'hA5, 8'hD2, 8'h1C});
		#1;
		chk("start", o_start, 1'b1);
		chk("id", o_match_id, 3'h0);
		chk("eval", o_end_eval, 1'b1);
		@(posedge i_ref_clk);
		#1;
		chk("pulse", o_start, 1'b0);
		wb(1'b0, msd_pkg::ADR_STATUS, 32'h0);
		chk("status eval", rd[0], 1'b1);
		u_char_source.send('{8'h6A, 8'h12, 8'h14, 8'h18, 8'h1C});
		#1;
		chk("no start in eval", o_start, 1'b0);
		@(posedge i_ref_clk);
		i_msg_end <= 1'b1;
		@(posedge i_ref_clk);
		i_msg_end <= 1'b0;
		#1;
		chk("eval end", o_end_eval, 1'b0);
	endtask

	// Overlapping candidates: 6A 6A 6A still ends after three
	task automatic t_three();
		wb(1'b1, msd_pkg::ADR_CTRL, 32'h00000103);
		u_char_source.send('{8'h6A, 8'h6A});
		#1;
		chk("short", o_start, 1'b0);
		u_char_source.send('{8'h6A});
		#1;
		chk("three", o_start, 1'b1);
		chk("id1", o_match_id, 3'h1);
	endtask

	// Status, end command, run clear, fifth slot and lowest index wins
	task automatic t_more();
		wb(1'b0, msd_pkg::ADR_STATUS, 32'h0);
		chk("status", rd, 32'h00000313);
		wb(1'b1, msd_pkg::ADR_STATUS, 32'h00000002);
		wb(1'b1, msd_pkg::ADR_END, 32'h00000001);
		wb(1'b0, msd_pkg::ADR_STATUS, 32'h0);
		chk("end cmd", rd, 32'h00000010);
		chk("end eval", o_end_eval, 1'b0);
		wb(1'b1, msd_pkg::ADR_SEQ_BASE + 8'h10, 32'h006A0000);
		wb(1'b1, msd_pkg::ADR_SEQ_BASE + 8'h14, 32'h00000400);
		wb(1'b1, msd_pkg::ADR_SEQ_BASE + 8'h20, 32'h44332211);
		wb(1'b1, msd_pkg::ADR_SEQ_BASE + 8'h24, 32'h00001F55);
		wb(1'b1, msd_pkg::ADR_CTRL, 32'h00000110);
		u_char_source.send('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
		#1;
		chk("fifth slot", o_start, 1'b1);
		chk("id4", o_match_id, 3'h4);
		wb(1'b1, msd_pkg::ADR_CTRL, 32'h00000016);
		wb(1'b1, msd_pkg::ADR_CTRL, 32'h00000116);
		chk("run clear", o_end_eval, 1'b0);
		u_char_source.send('{8'h6A, 8'h6A, 8'h6A});
		#1;
		chk("both", o_start, 1'b1);
		chk("lowest", o_match_id, 3'h1);
	endtask

	initial
	begin
		n_errors = 0;
		compares = 0;
		i_wb = '0;
		i_msg_end = 1'b0;
		i_sys_rst = 1'b1;
		repeat (10) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		t_config();
		t_five();
		t_three();
		t_more();
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
